/* logic/cmc_pkg.sv */
package cmc_pkg;

    // clock and bit cell
    localparam int CLK_MHZ = 125;
    localparam int BIT_NS = 100;

    // post-frame collision test: start delay and length
    localparam int WAIT_NS = 1000;
    localparam int TEST_BITS = 10;
    localparam int WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int TEST_CYC = (TEST_BITS * BIT_NS * CLK_MHZ + 999) / 1000;

    // jabber limit and unjab wait, in ms
    localparam longint JAB_MS = 50;
    localparam longint UNJAB_MS = 500;
    localparam longint JAB_CYC_DFLT = JAB_MS * CLK_MHZ * 1000;
    localparam longint UNJAB_CYC_DFLT = UNJAB_MS * CLK_MHZ * 1000;

    // widths
    localparam int TMR_W = 27;
    localparam int SHORT_W = 8;
    localparam int SYNC_N = 6;
    localparam int BUF_DEPTH = 2;

    // synchroniser lane positions
    localparam int LN_RX_DATA = 0;
    localparam int LN_RX_ACT = 1;
    localparam int LN_COLL2 = 2;
    localparam int LN_COLL3 = 3;
    localparam int LN_RPT = 4;
    localparam int LN_UNJAB = 5;

    // synchroniser reset value and strap wait count
    localparam logic [SYNC_N-1:0] SYNC_RST = 6'h00;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [1:0] {
        CMC_IF_IDLE = 2'b00,
        CMC_IF_TX = 2'b01,
        CMC_IF_WAIT = 2'b10,
        CMC_IF_TEST = 2'b11
    } cmc_if_state_t;

    typedef enum logic [1:0] {
        CMC_JB_OK = 2'b00,
        CMC_JB_JAB = 2'b01,
        CMC_JB_UNJAB = 2'b10
    } cmc_jab_state_t;

endpackage

/* logic/cmc_top.sv */
`timescale 1ns/1ns

// Functional notes
// - drop at most two leading transmit bits
// - only first transmitted bit may be bad
// - transmit latency at most half bit
// - transmit path keeps polarity
// - post-frame collision test, delayed and timed
// - receive start loss at most five bits
// - receive latency under half bit, no inversion
// - transmit and receive run together
// - collision circuit idle unless collision
// - collision shown within nine bits
// - never collision with single transmitter
// - thresholds depend on own transmitting
// - jabber cuts overlong transmission
// - jabber asserts collision presence
// - jabber cleared by reset or unjab wait
// - jabber outputs override normal outputs
// - repeater mode skips post-frame test
// - collision withdrawn within twenty bits
module cmc_top #(
    parameter logic [cmc_pkg::TMR_W-1:0] JAB_CYC =
        cmc_pkg::TMR_W'(cmc_pkg::JAB_CYC_DFLT),
    parameter logic [cmc_pkg::TMR_W-1:0] UNJAB_CYC =
        cmc_pkg::TMR_W'(cmc_pkg::UNJAB_CYC_DFLT)
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // transmit stream from station logic
    input wire logic do_valid_i,
    input wire logic do_data_i,
    output logic do_ready_o,
    // transmit stream to medium driver
    output logic md_valid_o,
    output logic md_data_o,
    input wire logic md_ready_i,
    // medium receiver pins
    input wire logic rx_data_i,
    input wire logic rx_active_i,
    input wire logic coll_two_i,
    input wire logic coll_three_i,
    // straps
    input wire logic repeater_i,
    input wire logic unjab_en_i,
    // station receive and control circuits
    output logic di_data_o,
    output logic di_active_o,
    output logic sqe_o,
    output logic jabber_o
);
    import cmc_pkg::*;

    // pin synchronisers
    logic [SYNC_N-1:0] pins;
    logic [SYNC_N-1:0] meta_q;
    logic [SYNC_N-1:0] sync_q;

    assign pins = {unjab_en_i, repeater_i, coll_three_i, coll_two_i,
                   rx_active_i, rx_data_i};

    genvar g;
    generate
        for (g = 0; g < SYNC_N; g++) begin : g_sync
            always_ff @(posedge clock_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q[g] <= SYNC_RST[g];
                    sync_q[g] <= SYNC_RST[g];
                end else begin
                    meta_q[g] <= pins[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    // straps are caught once, after the synchroniser has filled
    logic [1:0] strap_cnt_q;
    logic rpt_q;
    logic unjab_en_q;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_cnt_q <= 2'h0;
            rpt_q <= 1'b0;
            unjab_en_q <= 1'b0;
        end else if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_WAIT - 2'h1) begin
                rpt_q <= sync_q[LN_RPT];
                unjab_en_q <= sync_q[LN_UNJAB];
            end
        end
    end

    // state
    cmc_if_state_t if_q, if_d;
    cmc_jab_state_t jb_q, jb_d;
    logic [SHORT_W-1:0] short_q, short_d;
    logic [TMR_W-1:0] frame_q, frame_d;
    logic [TMR_W-1:0] unjab_q, unjab_d;
    logic do_prev_q;

    wire jab_on = (jb_q != CMC_JB_OK);
    wire frame_start = do_valid_i & ~do_prev_q;
    wire frame_over = (frame_q == JAB_CYC - TMR_W'(1));
    wire short_done_wait = (short_q == SHORT_W'(WAIT_CYC - 1));
    wire short_done_test = (short_q == SHORT_W'(TEST_CYC - 1));
    wire unjab_done = (unjab_q == UNJAB_CYC - TMR_W'(1));

    // two-entry transmit buffer
    logic [BUF_DEPTH-1:0] buf_q;
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;

    wire buf_full = (cnt_q == 2'(BUF_DEPTH));
    wire buf_empty = (cnt_q == 2'h0);
    // while jabbing the station is never stalled; its bits are dropped
    wire buf_wr = do_valid_i & ~buf_full & ~jab_on;
    wire buf_rd = md_valid_o & md_ready_i;

    assign do_ready_o = jab_on | ~buf_full;
    // an empty buffer passes a bit in one cycle, far under half a bit
    assign md_valid_o = ~buf_empty & ~jab_on;
    assign md_data_o = buf_q[rd_ptr_q];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buf_q <= '0;
        end else if (buf_wr) begin
            // every bit is kept, so none is lost at frame start
            buf_q[wr_ptr_q] <= do_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (jab_on) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ buf_wr;
            rd_ptr_q <= rd_ptr_q ^ buf_rd;
            cnt_q <= cnt_q + 2'(buf_wr) - 2'(buf_rd);
        end
    end

    // interface state machine
    always_comb begin
        if_d = if_q;
        short_d = short_q;
        case (if_q)
            CMC_IF_IDLE: begin
                if (do_valid_i) begin
                    if_d = CMC_IF_TX;
                end
            end
            CMC_IF_TX: begin
                if (!do_valid_i) begin
                    short_d = '0;
                    if_d = rpt_q ? CMC_IF_IDLE : CMC_IF_WAIT;
                end
            end
            CMC_IF_WAIT: begin
                short_d = short_q + SHORT_W'(1);
                if (do_valid_i) begin
                    if_d = CMC_IF_TX;
                end else if (short_done_wait) begin
                    short_d = '0;
                    if_d = CMC_IF_TEST;
                end
            end
            CMC_IF_TEST: begin
                short_d = short_q + SHORT_W'(1);
                if (short_done_test) begin
                    if_d = do_valid_i ? CMC_IF_TX : CMC_IF_IDLE;
                end
            end
            default: begin
                if_d = CMC_IF_IDLE;
            end
        endcase
        if (jab_on) begin
            // jabber overrides the normal sequence, no test afterwards
            if_d = CMC_IF_IDLE;
            short_d = '0;
        end
    end

    // jabber state machine
    always_comb begin
        jb_d = jb_q;
        frame_d = frame_q;
        unjab_d = unjab_q;
        if (frame_start) begin
            frame_d = '0;
        end else if (do_valid_i && !frame_over) begin
            frame_d = frame_q + TMR_W'(1);
        end
        case (jb_q)
            CMC_JB_OK: begin
                if (do_valid_i && frame_over) begin
                    jb_d = CMC_JB_JAB;
                end
            end
            CMC_JB_JAB: begin
                // without the unjab option only power reset clears it
                if (unjab_en_q && !do_valid_i) begin
                    unjab_d = '0;
                    jb_d = CMC_JB_UNJAB;
                end
            end
            CMC_JB_UNJAB: begin
                unjab_d = unjab_q + TMR_W'(1);
                if (do_valid_i) begin
                    jb_d = CMC_JB_JAB;
                end else if (unjab_done) begin
                    frame_d = '0;
                    jb_d = CMC_JB_OK;
                end
            end
            default: begin
                jb_d = CMC_JB_OK;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            if_q <= CMC_IF_IDLE;
            jb_q <= CMC_JB_OK;
            short_q <= '0;
            frame_q <= '0;
            unjab_q <= '0;
            do_prev_q <= 1'b0;
        end else begin
            if_q <= if_d;
            jb_q <= jb_d;
            short_q <= short_d;
            frame_q <= frame_d;
            unjab_q <= unjab_d;
            do_prev_q <= do_valid_i;
        end
    end

    // collision decision; the medium level comparators only trip at the
    // level of two or three transmitters, so one alone never counts
    wire own_tx = (if_q == CMC_IF_TX) & ~jab_on;
    wire coll_seen = own_tx ? sync_q[LN_COLL2]
                            : sync_q[LN_COLL3];
    wire sqe_d = jab_on | coll_seen | (if_q == CMC_IF_TEST);

    // receive path: three clock stages, 24 ns, no gating by transmit
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            di_data_o <= 1'b0;
            di_active_o <= 1'b0;
            sqe_o <= 1'b0;
            jabber_o <= 1'b0;
        end else begin
            di_data_o <= sync_q[LN_RX_DATA];
            di_active_o <= sync_q[LN_RX_ACT];
            sqe_o <= sqe_d;
            jabber_o <= jab_on;
        end
    end

endmodule // cmc_top

/* testbench/cmc_top_sva.sv */
`timescale 1ns/1ns
module cmc_top_sva #(
    parameter logic [cmc_pkg::TMR_W-1:0] JAB_CYC = 200
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // transmit stream
    input wire logic do_valid_i,
    input wire logic do_data_i,
    input wire logic do_ready_o,
    input wire logic md_valid_o,
    input wire logic md_data_o,
    input wire logic md_ready_i,
    // medium pins and straps
    input wire logic rx_data_i,
    input wire logic rx_active_i,
    input wire logic coll_two_i,
    input wire logic coll_three_i,
    input wire logic repeater_i,
    input wire logic unjab_en_i,
    // station side
    input wire logic di_data_o,
    input wire logic di_active_o,
    input wire logic sqe_o,
    input wire logic jabber_o
);
    import cmc_pkg::*;
    logic [1:0] up_q;
    logic [TMR_W-1:0] run_q;
    // pin pipelines hold reset values for three edges after release
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_q <= 2'h0;
            run_q <= '0;
        end else begin
            if (up_q != 2'h3) up_q <= up_q + 2'h1;
            if (!do_valid_i) run_q <= '0;
            else if (run_q <= JAB_CYC + 4) run_q <= run_q + TMR_W'(1);
        end
    end
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    a_rx_delay: assert property (
        up_q == 2'h3 |-> di_data_o == $past(rx_data_i, 3)
        && di_active_o == $past(rx_active_i, 3)) else $error("rx path");
    a_tx_order: assert property (
        do_valid_i && do_ready_o && !md_valid_o && !jabber_o
        |=> jabber_o || (md_valid_o && md_data_o == $past(do_data_i)))
        else $error("tx bit");
    a_tx_hold: assert property (
        md_valid_o && !md_ready_i && !jabber_o |=> $stable(md_data_o))
        else $error("tx stall");
    a_one_tx: assert property (
        (do_valid_i && !coll_two_i && !jabber_o)[*4] |-> !sqe_o)
        else $error("false collision");
    a_coll_tx: assert property (
        (do_valid_i && coll_two_i)[*5] |-> sqe_o) else $error("missed coll");
    a_test_start: assert property (
        $fell(do_valid_i) && !repeater_i && !jabber_o
        |-> ##[75:200] (sqe_o || do_valid_i)) else $error("no frame test");
    a_jab_out: assert property (
        jabber_o |-> sqe_o && !md_valid_o) else $error("jab outputs");
    a_jab_limit: assert property (
        run_q > JAB_CYC + 3 |-> jabber_o) else $error("no jab");
    cover property (jabber_o);
    cover property (sqe_o && !do_valid_i);
    cover property (md_valid_o && !md_ready_i);
endmodule // cmc_top_sva
bind cmc_top cmc_top_sva #(.JAB_CYC(JAB_CYC)) cmc_top_sva_inst (
    .clock_i, .arst_n_i, .do_valid_i, .do_data_i, .do_ready_o, .md_valid_o,
    .md_data_o, .md_ready_i, .rx_data_i, .rx_active_i, .coll_two_i,
    .coll_three_i, .repeater_i, .unjab_en_i, .di_data_o, .di_active_o,
    .sqe_o, .jabber_o);

/* testbench/cmc_medium_model.sv */
`timescale 1ns/1ns
module cmc_medium_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // driver stream
    input wire logic md_valid_i,
    input wire logic md_data_i,
    input wire logic stall_i,
    output logic md_ready_o,
    // receive pins and capture
    output logic rx_data_o,
    output logic rx_active_o,
    output logic [15:0] got_o,
    output logic [7:0] cnt_o
);
    logic line_q;
    assign md_ready_o = !stall_i;
    assign rx_active_o = md_valid_i;
    // idle line wanders so a stale bit never looks like data
    assign rx_data_o = md_valid_i ? md_data_i : line_q;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_q <= 1'b0;
            got_o <= 16'h0000;
            cnt_o <= 8'h00;
        end else begin
            line_q <= !line_q;
            if (md_valid_i && md_ready_o) begin
                got_o <= {got_o[14:0], md_data_i};
                cnt_o <= cnt_o + 8'h01;
            end
        end
    end
endmodule // cmc_medium_model

/* testbench/coax_mau_control_bench.sv */
`timescale 1ns/1ns
module coax_mau_control_bench;
    import cmc_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic do_valid_i = 1'b0;
    logic do_data_i = 1'b0;
    logic repeater_i = 1'b0;
    logic unjab_en_i = 1'b1;
    logic coll_two_i = 1'b0;
    logic coll_three_i = 1'b0;
    logic stall = 1'b0;
    logic do_ready_o, md_valid_o, md_data_o, md_ready_i, rx_data_i;
    logic rx_active_i, di_data_o, di_active_o, sqe_o, jabber_o;
    logic [15:0] got;
    logic [7:0] cnt;
    int num_errors = 0;
    int check_count = 0;
    int n;
    int m;
    // row bits: transmitting, two-level pin, three-level pin, sqe expected
    logic [3:0] rows [6] = '{4'h0, 4'h4, 4'h7, 4'h8, 4'hd, 4'hf};
    always #4 clock_i = ~clock_i;
    cmc_top #(.JAB_CYC(27'h00c8), .UNJAB_CYC(27'h012c)) cmc_top_inst (
        .clock_i, .arst_n_i, .do_valid_i, .do_data_i, .do_ready_o,
        .md_valid_o, .md_data_o, .md_ready_i, .rx_data_i, .rx_active_i,
        .coll_two_i, .coll_three_i, .repeater_i, .unjab_en_i,
        .di_data_o, .di_active_o, .sqe_o, .jabber_o);
    cmc_medium_model cmc_medium_model_inst (
        .clock_i, .arst_n_i, .md_valid_i(md_valid_o), .md_data_i(md_data_o),
        .stall_i(stall), .md_ready_o(md_ready_i), .rx_data_o(rx_data_i),
        .rx_active_o(rx_active_i), .got_o(got), .cnt_o(cnt));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic restart(input logic rpt);
        arst_n_i = 1'b0;
        repeater_i = rpt;
        tick(20);
        check({do_ready_o, md_valid_o, sqe_o, jabber_o}, 16'h0008);
        arst_n_i = 1'b1;
        tick(5);
    endtask
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            do_valid_i = 1'b1;
            do_data_i = w[i];
            n = 0;
            do begin
                @(posedge clock_i);
                n++;
            end while (do_ready_o !== 1'b1 && n < 40);
            #1;
            if (n == 40) num_errors++;
            if (n == 40) print_verdict();
        end
        do_valid_i = 1'b0;
    endtask
    task automatic until_sqe(input logic lvl);
        m = 0;
        while (sqe_o !== lvl && m < 300) begin
            tick(1);
            m++;
        end
    endtask
    initial begin
        restart(1'b0);
        foreach (rows[r]) begin
            {do_valid_i, coll_two_i, coll_three_i} = rows[r][3:1];
            tick(8);
            check(sqe_o, rows[r][0]);
            check(di_active_o, rows[r][3]);
            {do_valid_i, coll_two_i, coll_three_i} = 3'h0;
            tick(300);
        end
        $display("test collision done");
        restart(1'b0);
        stall = 1'b1;
        fork
            send(16'ha5c3);
            begin
                tick(10);
                stall = 1'b0;
            end
        join
        tick(4);
        check(got, 16'ha5c3);
        check(cnt, 16'h0010);
        until_sqe(1'b1);
        check(m >= 71 && m <= 196, 1'b1);
        until_sqe(1'b0);
        check(m >= 63 && m <= 188, 1'b1);
        $display("test frame done");
        do_valid_i = 1'b1;
        tick(150);
        do_valid_i = 1'b0;
        tick(20);
        do_valid_i = 1'b1;
        tick(150);
        check(jabber_o, 1'b0);
        tick(60);
        check({jabber_o, sqe_o, md_valid_o}, 16'h0006);
        do_valid_i = 1'b0;
        tick(290);
        check(jabber_o, 1'b1);
        tick(30);
        check(jabber_o, 1'b0);
        $display("test jabber done");
        restart(1'b1);
        send(16'h00ff);
        n = 0;
        repeat (300) begin
            tick(1);
            if (sqe_o !== 1'b0) n++;
        end
        check(16'(n), 16'h0000);
        $display("test repeater done");
        print_verdict();
    end
endmodule // coax_mau_control_bench
